/* File: bench/lfs_host_model.sv */
`timescale 1ns/10ps
module lfs_host_model (
  input wire logic aclk,
  input wire logic fault_n_oe,
  output logic enable_input,
  output logic pwm_in,
  output logic fault_line
);
  // open-drain fault pin, pulled up on the host side
  assign fault_line = fault_n_oe ? 1'b0 : 1'b1;
  initial begin
    enable_input = 1'b0;
    pwm_in = 1'b0;
  end
  // level changes land just after a clock edge
  task automatic set_en(input logic v);
    @(posedge aclk);
    enable_input <= v;
  endtask
  task automatic set_pwm(input logic v);
    @(posedge aclk);
    pwm_in <= v;
  endtask
  // low pulse meant to clear string faults without a shutdown
  task automatic pulse_low(input int n);
    @(posedge aclk);
    enable_input <= 1'b0;
    repeat (n) @(posedge aclk);
    enable_input <= 1'b1;
  endtask
endmodule // lfs_host_model

/* File: bench/lfs_seq_monitor.sv */
`timescale 1ns/10ps
module lfs_seq_monitor
  import lfs_pkg::*;
#(
  parameter int N = NUM_STRINGS,
  parameter int SOFT_CYCLES = SOFT_CYC,
  parameter int BOOST_CYCLES = BOOST_CYC,
  parameter int RECOV_CYCLES = RECOV_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable_input,
  input wire logic pwm_in,
  input wire lfs_flags_t flags_in,
  input wire lfs_sink_cmp_t sink_cmp_in,
  input wire logic fault_n_oe,
  input wire logic regulator_en,
  input wire logic power_switch_en,
  input wire logic boost_en,
  input wire logic boost_reduced_limit,
  input wire logic boost_raise,
  input wire logic [N-1:0] sink_output,
  input wire logic [N-1:0] regulation_mask
);
  int soft_cnt;
  int boost_cnt;
  int rec_cnt;
  default clocking lfs_cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // phase lengths, read back when the following phase starts
  always_ff @(posedge aclk) begin
    soft_cnt <= (!aresetn || !power_switch_en || boost_en) ? 0 : soft_cnt + 1;
    boost_cnt <= (!aresetn || !boost_reduced_limit) ? 0 : boost_cnt + 1;
    rec_cnt <= (!aresetn || !regulator_en || power_switch_en) ? 0 : rec_cnt + 1;
  end
  // short string held long enough to pass the input synchronisers
  sequence s_short_held;
    (boost_en && !boost_reduced_limit && (|sink_cmp_in.above_high)
      && (|(sink_cmp_in.below_mid & ~sink_cmp_in.below_low))) [*4];
  endsequence
  sequence s_fault_shown;
    ##[1:3] fault_n_oe;
  endsequence
  property p_short; s_short_held |-> s_fault_shown; endproperty
  a_short: assert property (p_short) else $error("short string not flagged");
  property p_sink_pwm; !pwm_in [*4] |=> sink_output == '0; endproperty
  a_sink_pwm: assert property (p_sink_pwm) else $error("sink on with pwm low");
  property p_sink_en; !enable_input [*4] |=> sink_output == '0; endproperty
  a_sink_en: assert property (p_sink_en) else $error("sink on with enable low");
  property p_sink_mask; sink_output != '0 |->
    (sink_output & ~regulation_mask) == '0 && boost_en && !boost_reduced_limit; endproperty
  a_sink_mask: assert property (p_sink_mask) else $error("sink on outside regulated set");
  property p_off_together; boost_en |-> power_switch_en && regulator_en; endproperty
  a_off_together: assert property (p_off_together) else $error("boost on without line switch");
  property p_limit; boost_reduced_limit |-> boost_en && sink_output == '0; endproperty
  a_limit: assert property (p_limit) else $error("reduced limit outside boost start");
  property p_raise; boost_raise |-> boost_en && !boost_reduced_limit; endproperty
  a_raise: assert property (p_raise) else $error("boost raise outside normal");
  property p_soft_time; $rose(boost_en) |-> soft_cnt inside {[SOFT_CYCLES-1:SOFT_CYCLES+1]}; endproperty
  a_soft_time: assert property (p_soft_time) else $error("soft start length wrong");
  property p_boost_time; $fell(boost_reduced_limit) && boost_en |->
    boost_cnt inside {[BOOST_CYCLES-1:BOOST_CYCLES+1]}; endproperty
  a_boost_time: assert property (p_boost_time) else $error("boost start length wrong");
  property p_recov_time; $rose(power_switch_en) |-> rec_cnt == 0 || rec_cnt >= RECOV_CYCLES; endproperty
  a_recov_time: assert property (p_recov_time) else $error("recovery left too early");
  property p_recov_fault; regulator_en && !power_switch_en &&
    $past(regulator_en) && !$past(power_switch_en) |-> fault_n_oe; endproperty
  a_recov_fault: assert property (p_recov_fault) else $error("fault released in recovery");
  property p_supply; (boost_en && (flags_in.input_overvoltage_fault || flags_in.input_undervoltage_fault
    || flags_in.switch_node_overvoltage_fault || flags_in.die_overtemperature_fault)) [*3] |-> ##[1:4] !boost_en; endproperty
  a_supply: assert property (p_supply) else $error("supply fault ignored");
endmodule // lfs_seq_monitor

bind lfs_sequencer lfs_seq_monitor #(.N(N), .SOFT_CYCLES(SOFT_CYCLES), .BOOST_CYCLES(BOOST_CYCLES),
  .RECOV_CYCLES(RECOV_CYCLES)) u_lfs_seq_monitor (.aclk(aclk), .aresetn(aresetn), .enable_input(enable_input),
  .pwm_in(pwm_in), .flags_in(flags_in), .sink_cmp_in(sink_cmp_in), .fault_n_oe(fault_n_oe),
  .regulator_en(regulator_en), .power_switch_en(power_switch_en), .boost_en(boost_en),
  .boost_reduced_limit(boost_reduced_limit), .boost_raise(boost_raise), .sink_output(sink_output),
  .regulation_mask(regulation_mask));

/* File: bench/tb.sv */
`timescale 1ns/10ps
`define CHK(a, e) chk(32'(a), 32'(e))
module tb;
  import lfs_pkg::*;
  localparam int SC = 100;
  localparam int BC = 100;
  localparam int RC = 200;
  localparam int FC = 150;
  localparam int STC = 2500;
  logic aclk, aresetn, enable_input, pwm_in, fault_line, fault_n_out, fault_n_oe;
  logic regulator_en, power_switch_en, boost_en, boost_reduced_limit, boost_raise;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [3:0] sink_output, regulation_mask, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  lfs_flags_t flags_in;
  lfs_sink_cmp_t sink_cmp_in;
  int errors, checks, cyc;
  int pos[4] = '{5, 4, 2, 1};
  logic [4:0] cause[4] = '{5'h10, 5'h08, 5'h02, 5'h01};

  lfs_sequencer #(.STBY_CYCLES(STC), .SOFT_CYCLES(SC), .BOOST_CYCLES(BC), .RECOV_CYCLES(RC), .FBOV_CYCLES(FC))
  u_lfs_sequencer (.aclk(aclk), .aresetn(aresetn), .enable_input(enable_input), .pwm_in(pwm_in),
    .flags_in(flags_in), .sink_cmp_in(sink_cmp_in), .fault_n_out(fault_n_out), .fault_n_oe(fault_n_oe),
    .regulator_en(regulator_en), .power_switch_en(power_switch_en), .boost_en(boost_en),
    .boost_reduced_limit(boost_reduced_limit), .boost_raise(boost_raise), .sink_output(sink_output),
    .regulation_mask(regulation_mask), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
  lfs_host_model u_lfs_host_model (.aclk(aclk), .fault_n_oe(fault_n_oe), .enable_input(enable_input),
    .pwm_in(pwm_in), .fault_line(fault_line));

  // clock and hang guard
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      end_sim();
    end
  end
  function automatic void chk(input logic [31:0] a, input logic [31:0] e);
    checks++;
    if (a !== e) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, a, e);
    end
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // bus write: address and data offered together, each dropped once taken
  task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rsp);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) {s_axi_awvalid, s_axi_bready} <= 2'b01;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rsp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) {s_axi_arvalid, s_axi_rready} <= 2'b01;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic st(input lfs_state_t s);
    rd(REG_STATUS, d, r);
    `CHK(d[2:0], s);
  endtask
  task automatic t_reset();
    `CHK({regulator_en, power_switch_en, boost_en, fault_n_oe, sink_output, fault_n_out}, 9'h0);
    `CHK({s_axi_awready, s_axi_wready, s_axi_arready}, 3'b111);
    rd(REG_CTRL, d, r);
    `CHK(d[1:0], CTRL_RESET);
    st(LFS_OFF);
    flags_in.supply_ok <= 1'b1;
    w(6);
    st(LFS_STANDBY);
    $display("test reset done");
  endtask
  task automatic t_start();
    u_lfs_host_model.set_pwm(1'b1);
    u_lfs_host_model.set_en(1'b1);
    w(6);
    st(LFS_SOFT);
    `CHK({regulator_en, power_switch_en, boost_en}, 3'b110);
    w(SC);
    `CHK({boost_en, boost_reduced_limit, sink_output}, 6'b110000);
    w(BC + 10);
    st(LFS_NORMAL);
    rd(REG_STRINGS, d, r);
    `CHK({d[19:16], regulation_mask, sink_output}, 12'h877);
    u_lfs_host_model.set_pwm(1'b0);
    w(5);
    `CHK(sink_output, 4'h0);
    u_lfs_host_model.set_pwm(1'b1);
    w(5);
    $display("test start done");
  endtask
  task automatic t_short();
    sink_cmp_in <= {4'h0, 4'hD, 4'h2, 4'h8};
    w(8);
    rd(REG_STRINGS, d, r);
    `CHK({d[11:8], sink_output, regulation_mask, fault_line}, 13'h04AA);
    st(LFS_NORMAL);
    sink_cmp_in.above_high <= 4'b0000;
    u_lfs_host_model.pulse_low(100);
    w(8);
    `CHK(fault_line, 1'b0);
    u_lfs_host_model.pulse_low(1000);
    w(8);
    rd(REG_STRINGS, d, r);
    `CHK({d[11:8], sink_output, fault_line}, 9'h00F);
    st(LFS_NORMAL);
    $display("test short done");
  endtask
  task automatic t_open();
    sink_cmp_in.below_low <= 4'b0001;
    w(6);
    `CHK(boost_raise, 1'b1);
    wr(REG_CTRL, 32'h0000_0002, r);
    w(4);
    rd(REG_CTRL, d, r);
    `CHK({boost_raise, d[1:0]}, 3'b010);
    wr(REG_CTRL, 32'h0000_0000, r);
    flags_in.adaptive_at_max <= 1'b1;
    sink_cmp_in.below_low <= 4'b0100;
    w(8);
    rd(REG_STRINGS, d, r);
    `CHK({d[3:0], sink_output, fault_line}, 9'h086);
    flags_in.adaptive_at_max <= 1'b0;
    sink_cmp_in.below_low <= 4'b0000;
    wr(REG_CTRL, 32'h0000_0001, r);
    `CHK(r, RESP_OKAY);
    w(6);
    rd(REG_STRINGS, d, r);
    `CHK({d[3:0], fault_line}, 5'h01);
    $display("test open done");
  endtask
  task automatic t_fbov();
    flags_in.feedback_over <= 1'b1;
    w(FC - 50);
    flags_in.feedback_over <= 1'b0;
    w(4);
    st(LFS_NORMAL);
    flags_in.feedback_over <= 1'b1;
    w(FC + 10);
    st(LFS_RECOVERY);
    `CHK(d[8:4], 5'b00100);
    `CHK({power_switch_en, boost_en, sink_output, fault_line}, 7'h0);
    flags_in.feedback_over <= 1'b0;
    w(RC);
    `CHK(power_switch_en, 1'b1);
    w(SC + BC + 10);
    st(LFS_NORMAL);
    `CHK(fault_line, 1'b1);
    $display("test feedback done");
  endtask
  task automatic t_supply();
    for (int i = 0; i < 4; i++) begin
      flags_in[pos[i]] <= 1'b1;
      w(8);
      st(LFS_RECOVERY);
      `CHK(d[8:4], cause[i]);
      flags_in[pos[i]] <= 1'b0;
      w(RC + SC + BC + 20);
      st(LFS_NORMAL);
    end
    flags_in.die_overtemperature_fault <= 1'b1;
    w(RC + 60);
    st(LFS_RECOVERY);
    flags_in.die_overtemperature_fault <= 1'b0;
    w(10);
    `CHK(power_switch_en, 1'b1);
    flags_in.feedback_over <= 1'b1;
    sink_cmp_in.above_high <= 4'b0010;
    w(SC / 2);
    st(LFS_SOFT);
    rd(REG_STRINGS, d, r);
    `CHK(d[11:8], 4'h0);
    flags_in.feedback_over <= 1'b0;
    sink_cmp_in.above_high <= 4'b0000;
    w(SC + BC);
    st(LFS_NORMAL);
    $display("test supply done");
  endtask
  task automatic t_standby();
    rd(4'hC, d, r);
    `CHK({r, d[29:0]}, {RESP_SLVERR, 30'h0});
    wr(4'hC, 32'h0000_0001, r);
    `CHK(r, RESP_SLVERR);
    u_lfs_host_model.set_en(1'b0);
    w(STC + 100);
    st(LFS_STANDBY);
    `CHK({regulator_en, power_switch_en, sink_output}, 6'h0);
    u_lfs_host_model.set_en(1'b1);
    w(8);
    st(LFS_SOFT);
    $display("test standby done");
  endtask

  // reset for three cycles, then the scenarios in order
  initial begin
    errors = 0;
    checks = 0;
    cyc = 0;
    aresetn = 1'b0;
    flags_in = '0;
    sink_cmp_in = {4'h0, 4'hF, 4'h0, 4'h8};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    w(2);
    t_reset();
    t_start();
    t_short();
    t_open();
    t_fbov();
    t_supply();
    t_standby();
    end_sim();
  end
endmodule // tb

/* File: logic/lfs_pkg.sv */
package lfs_pkg;
  // clock rate and documented times, each in its own unit
  localparam int CLK_HZ = 100_000_000;
  localparam int PULSE_MIN_NS = 2_000;
  localparam int PULSE_MAX_NS = 20_000;
  localparam int STBY_LOW_NS = 50_000;
  localparam int SOFT_MS = 65;
  localparam int BOOST_MS = 50;
  localparam int RECOV_MS = 100;
  localparam int FBOV_MS = 560;
  // derived cycle counts: least times round up, longest times round down
  localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int PULSE_MAX_CYC = PULSE_MAX_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int STBY_LOW_CYC = (STBY_LOW_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int SOFT_CYC = SOFT_MS * (CLK_HZ / 1000);
  localparam int BOOST_CYC = BOOST_MS * (CLK_HZ / 1000);
  localparam int RECOV_CYC = RECOV_MS * (CLK_HZ / 1000);
  localparam int FBOV_CYC = FBOV_MS * (CLK_HZ / 1000);
  localparam int NUM_STRINGS = 4;

  // register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_STRINGS = 4'h8;
  // field positions
  localparam int CTRL_CLR_BIT = 0;
  localparam int CTRL_NORAISE_BIT = 1;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_FAULT_BIT = 3;
  localparam int STAT_CAUSE_LSB = 4;
  localparam int STR_OPEN_LSB = 0;
  localparam int STR_SHORT_LSB = 8;
  localparam int STR_GND_LSB = 16;
  // reset values and bus answers
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    LFS_OFF = 3'b000,
    LFS_STANDBY = 3'b001,
    LFS_SOFT = 3'b010,
    LFS_BOOST = 3'b011,
    LFS_NORMAL = 3'b100,
    LFS_RECOVERY = 3'b101
  } lfs_state_t;

  // supply and converter comparator results
  typedef struct packed {
    logic supply_ok;
    logic input_overvoltage_fault;
    logic input_undervoltage_fault;
    logic feedback_over;
    logic switch_node_overvoltage_fault;
    logic die_overtemperature_fault;
    logic adaptive_at_max;
  } lfs_flags_t;

  // per-string sink comparator results
  typedef struct packed {
    logic [NUM_STRINGS-1:0] below_low;
    logic [NUM_STRINGS-1:0] below_mid;
    logic [NUM_STRINGS-1:0] above_high;
    logic [NUM_STRINGS-1:0] grounded;
  } lfs_sink_cmp_t;

  // recovery cause field
  typedef struct packed {
    logic in_ov;
    logic in_uv;
    logic out_ov;
    logic sw_ov;
    logic temp;
  } lfs_cause_t;
endpackage

/* File: logic/lfs_sequencer.sv */
// Added by the designer: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
// Notes on behaviour
// - short string: one sink above high while another sits in the low-mid window
// - a shorted string leaves boost regulation and its sink is switched off
// - open string: boost at max and a sink still below low; drop and disable it
// - open and short detection only run in normal state
// - string faults keep normal running, pull fault output low, no recovery
// - enable low 2-20 us in normal clears string faults, releases fault, blanks LEDs
// - enable low over 50 us returns to standby; restart when enable rises
// - overtemperature stops power-line switch, boost and sinks (regulator stays on), fault low, restart only once flag clears
// - every non-string fault enters recovery with converter and sinks off, fault low
// - recovery disables sinks, boost and power-line switch together
// - after 100 ms in recovery restart from soft start if enable is high
// - reaching normal with no fault releases the fault output
// - output overvoltage counts only after 560 ms of feedback overvoltage
// - standby is entered once the supply is above its release threshold
// - enable high in standby wakes the regulator and enters soft start
// - soft start turns on the power-line switch, 65 ms later boost start
// - soft and boost start watch only input ov/uv, switch-node ov and temperature
// - boost start enables the converter with a reduced current limit
// - after 50 ms boost start tests grounded sinks once, drops them, enters normal
// - in normal the sinks follow the brightness pwm input
// - normal state watches every fault type
// - in normal raise the boost target when a used sink is below low
module lfs_sequencer
  import lfs_pkg::*;
#(
  parameter int N = NUM_STRINGS,
  parameter int STBY_CYCLES = STBY_LOW_CYC,
  parameter int SOFT_CYCLES = SOFT_CYC,
  parameter int BOOST_CYCLES = BOOST_CYC,
  parameter int RECOV_CYCLES = RECOV_CYC,
  parameter int FBOV_CYCLES = FBOV_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic enable_input,
  input wire logic pwm_in,
  input wire lfs_flags_t flags_in,
  input wire lfs_sink_cmp_t sink_cmp_in,
  output logic fault_n_out,
  output logic fault_n_oe,
  output logic regulator_en,
  output logic power_switch_en,
  output logic boost_en,
  output logic boost_reduced_limit,
  output logic boost_raise,
  output logic [N-1:0] sink_output,
  output logic [N-1:0] regulation_mask,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  localparam int SYNC_W = $bits(lfs_flags_t) + $bits(lfs_sink_cmp_t) + 2;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_out;
  lfs_flags_t fl;
  lfs_sink_cmp_t sc;
  logic en_s;
  logic pwm_s;
  lfs_state_t state;
  lfs_state_t next_state;
  logic [31:0] st_cnt;
  logic [31:0] low_cnt;
  logic [31:0] fbov_cnt;
  logic en_prev;
  logic fault_low;
  logic [N-1:0] used;
  logic [N-1:0] open_flt;
  logic [N-1:0] short_flt;
  logic [N-1:0] window;
  logic [N-1:0] short_set;
  logic [N-1:0] open_set;
  logic [N-1:0] active;
  logic clr_pulse;
  logic en_long_low;
  logic supply_flt;
  logic out_ov;
  lfs_cause_t cause;
  logic [1:0] ctrl;
  logic sw_clear;
  logic aw_full;
  logic w_full;
  logic [3:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // two-stage synchroniser; the first stage feeds only the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_meta <= '0;
      sync_out <= '0;
    end else begin
      sync_meta <= {flags_in, sink_cmp_in, enable_input, pwm_in};
      sync_out <= sync_meta;
    end
  end

  assign {fl, sc, en_s, pwm_s} = sync_out;

  // string comparator decode; grounded or faulted strings take no part
  assign active = used & ~open_flt & ~short_flt;
  assign window = active & ~sc.below_low & sc.below_mid;
  generate
    for (genvar i = 0; i < N; i++) begin : g_str
      assign short_set[i] = active[i] && sc.above_high[i] &&
        ((window & ~(N'(1) << i)) != '0);
      assign open_set[i] = active[i] && fl.adaptive_at_max && sc.below_low[i];
    end
  endgenerate

  // enable pulse classification: clear pulse on the rising edge, long low while enable is still low
  assign clr_pulse = en_s && !en_prev && state == LFS_NORMAL &&
    low_cnt >= 32'(PULSE_MIN_CYC) && low_cnt <= 32'(PULSE_MAX_CYC);
  assign en_long_low = !en_s && low_cnt >= 32'(STBY_CYCLES);

  // supply faults are live in soft start, boost start and normal
  assign supply_flt = fl.input_overvoltage_fault || fl.input_undervoltage_fault ||
    fl.switch_node_overvoltage_fault || fl.die_overtemperature_fault;
  assign out_ov = state == LFS_NORMAL && fbov_cnt >= 32'(FBOV_CYCLES);

  // next state
  always_comb begin
    next_state = state;
    case (state)
      LFS_OFF: begin
        if (fl.supply_ok) begin
          next_state = LFS_STANDBY;
        end
      end
      LFS_STANDBY: begin
        if (en_s) begin
          next_state = LFS_SOFT;
        end
      end
      LFS_SOFT: begin
        if (supply_flt) begin
          next_state = LFS_RECOVERY;
        end else if (en_long_low) begin
          next_state = LFS_STANDBY;
        end else if (st_cnt >= 32'(SOFT_CYCLES - 1)) begin
          next_state = LFS_BOOST;
        end
      end
      LFS_BOOST: begin
        if (supply_flt) begin
          next_state = LFS_RECOVERY;
        end else if (en_long_low) begin
          next_state = LFS_STANDBY;
        end else if (st_cnt >= 32'(BOOST_CYCLES - 1)) begin
          next_state = LFS_NORMAL;
        end
      end
      LFS_NORMAL: begin
        if (supply_flt || out_ov) begin
          next_state = LFS_RECOVERY;
        end else if (en_long_low) begin
          next_state = LFS_STANDBY;
        end
      end
      LFS_RECOVERY: begin
        if (en_long_low) begin
          next_state = LFS_STANDBY;
        end else if (st_cnt >= 32'(RECOV_CYCLES - 1) && en_s &&
                     !fl.die_overtemperature_fault) begin
          next_state = LFS_SOFT;
        end
      end
      default: next_state = LFS_OFF;
    endcase
  end

  // state register and dwell timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= LFS_OFF;
      st_cnt <= '0;
    end else begin
      state <= next_state;
      st_cnt <= (next_state != state) ? 32'h0000_0000 : st_cnt + 32'h0000_0001;
    end
  end

  // enable low-time counter, saturating so a long low stays long
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      low_cnt <= '0;
      en_prev <= 1'b0;
    end else begin
      en_prev <= en_s;
      if (en_s) begin
        low_cnt <= '0;
      end else if (low_cnt != 32'hFFFF_FFFF) begin
        low_cnt <= low_cnt + 32'h0000_0001;
      end
    end
  end

  // feedback overvoltage persistence, normal state only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fbov_cnt <= '0;
    end else if (state == LFS_NORMAL && fl.feedback_over) begin
      if (fbov_cnt < 32'(FBOV_CYCLES)) begin
        fbov_cnt <= fbov_cnt + 32'h0000_0001;
      end
    end else begin
      fbov_cnt <= '0;
    end
  end

  // grounded sink test, done once as boost start ends
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      used <= '1;
    end else if (state == LFS_STANDBY) begin
      used <= '1;
    end else if (state == LFS_BOOST && next_state == LFS_NORMAL) begin
      used <= ~sc.grounded;
    end
  end

  // string faults: a new detection wins over a clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_flt <= '0;
      short_flt <= '0;
    end else if (state == LFS_STANDBY) begin
      open_flt <= '0;
      short_flt <= '0;
    end else if (state == LFS_NORMAL) begin
      if (clr_pulse || sw_clear) begin
        open_flt <= open_set;
        short_flt <= short_set;
      end else begin
        open_flt <= open_flt | open_set;
        short_flt <= short_flt | short_set;
      end
    end
  end

  // fault output level and latched recovery cause
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_low <= 1'b0;
      cause <= '0;
    end else if (next_state == LFS_RECOVERY && state != LFS_RECOVERY) begin
      fault_low <= 1'b1;
      cause <= '{fl.input_overvoltage_fault, fl.input_undervoltage_fault, out_ov,
                 fl.switch_node_overvoltage_fault, fl.die_overtemperature_fault};
    end else if (state == LFS_NORMAL && ((open_set | short_set) != '0)) begin
      fault_low <= 1'b1;
    end else if (state == LFS_BOOST && next_state == LFS_NORMAL &&
                 ((open_flt | short_flt) == '0)) begin
      fault_low <= 1'b0;
    end else if (clr_pulse || (sw_clear && state == LFS_NORMAL)) begin
      fault_low <= 1'b0;
    end
  end

  // power stage and sink controls, all registered
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_n_out <= 1'b0;
      fault_n_oe <= 1'b0;
      regulator_en <= 1'b0;
      power_switch_en <= 1'b0;
      boost_en <= 1'b0;
      boost_reduced_limit <= 1'b0;
      boost_raise <= 1'b0;
      sink_output <= '0;
      regulation_mask <= '0;
    end else begin
      fault_n_out <= 1'b0;
      fault_n_oe <= fault_low;
      regulator_en <= state inside {LFS_SOFT, LFS_BOOST, LFS_NORMAL, LFS_RECOVERY};
      power_switch_en <= state inside {LFS_SOFT, LFS_BOOST, LFS_NORMAL};
      boost_en <= state inside {LFS_BOOST, LFS_NORMAL};
      boost_reduced_limit <= state == LFS_BOOST;
      boost_raise <= state == LFS_NORMAL && !ctrl[CTRL_NORAISE_BIT] &&
        ((active & sc.below_low) != '0);
      sink_output <= (state == LFS_NORMAL && pwm_s && en_s) ? active : '0;
      regulation_mask <= active;
    end
  end

  // axi write: address and data taken independently, answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      ctrl <= CTRL_RESET;
      sw_clear <= 1'b0;
    end else begin
      sw_clear <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_full <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_full <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_full && w_full && !s_axi_bvalid) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr == REG_CTRL) begin
          s_axi_bresp <= RESP_OKAY;
          if (w_strb[0]) begin
            ctrl[CTRL_NORAISE_BIT] <= w_data[CTRL_NORAISE_BIT];
            sw_clear <= w_data[CTRL_CLR_BIT];
          end
        end else if (aw_addr == REG_STATUS || aw_addr == REG_STRINGS) begin
          s_axi_bresp <= RESP_OKAY; // read-only, write ignored
        end else begin
          s_axi_bresp <= RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // axi read: one access in flight, data one cycle after the address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= '0;
      case (s_axi_araddr)
        REG_CTRL: s_axi_rdata[CTRL_NORAISE_BIT] <= ctrl[CTRL_NORAISE_BIT];
        REG_STATUS: begin
          s_axi_rdata[STAT_STATE_LSB +: 3] <= state;
          s_axi_rdata[STAT_FAULT_BIT] <= fault_low;
          s_axi_rdata[STAT_CAUSE_LSB +: 5] <= cause;
        end
        REG_STRINGS: begin
          s_axi_rdata[STR_OPEN_LSB +: N] <= open_flt;
          s_axi_rdata[STR_SHORT_LSB +: N] <= short_flt;
          s_axi_rdata[STR_GND_LSB +: N] <= ~used;
        end
        default: s_axi_rresp <= RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule // lfs_sequencer
